/* File: nrs_defines.vh */
// constants for the receive status and configuration register bank
`ifndef NRS_DEFINES_VH
`define NRS_DEFINES_VH
// register indices, byte address is four times the index
`define NRS_IX_CMD 4'h0
`define NRS_IX_LDMA_LO 4'h1
`define NRS_IX_LDMA_HI 4'h2
`define NRS_IX_BOUNDARY 4'h3
`define NRS_IX_TX_START 4'h4
`define NRS_IX_TX_CNT_LO 4'h5
`define NRS_IX_TX_CNT_HI 4'h6
`define NRS_IX_CUR_PAGE 4'h7
`define NRS_IX_RDMA_LO 4'h8
`define NRS_IX_RDMA_HI 4'h9
`define NRS_IX_RCNT_LO 4'ha
`define NRS_IX_RCNT_HI 4'hb
`define NRS_IX_RX_STATUS 4'hc
`define NRS_IX_ALIGN_TALLY 4'hd
`define NRS_IX_CRC_TALLY 4'he
`define NRS_IX_MISS_TALLY 4'hf
`define NRS_IX_STA_FIRST 4'h1
`define NRS_IX_STA_LAST 4'h6
`define NRS_IX_MCAST_FIRST 4'h8
`define NRS_IX_EE_CMD 4'h1
`define NRS_IX_BOOT_PAGE 4'h2
`define NRS_IX_CFG0 4'h3
`define NRS_IX_CFG1 4'h4
`define NRS_IX_CFG2 4'h5
`define NRS_IX_CFG3 4'h6
`define NRS_IX_TEST 4'h7
`define NRS_IX_CARD_NUM 4'h8
`define NRS_IX_CLK_HALT 4'h9
`define NRS_IX_INT_STATE 4'hb
`define NRS_IX_CFG4 4'hd
// pages
`define NRS_PAGE0 2'h0
`define NRS_PAGE1 2'h1
`define NRS_PAGE2 2'h2
`define NRS_PAGE3 2'h3
// receive status bit positions
`define NRS_RS_DEFER 7
`define NRS_RS_DISABLED 6
`define NRS_RS_GROUP 5
`define NRS_RS_MISSED 4
`define NRS_RS_ONE 3
`define NRS_RS_ALIGN 2
`define NRS_RS_CRC 1
`define NRS_RS_OK 0
// eeprom operating modes
`define NRS_EEM_NORMAL 2'h0
`define NRS_EEM_AUTOLOAD 2'h1
`define NRS_EEM_PROGRAM 2'h2
`define NRS_EEM_CFG_WRITE 2'h3
// reset values
`define NRS_RST_CMD 8'h21
`define NRS_RST_ZERO 8'h00
`define NRS_RST_CLK_HALT 8'hff
`define NRS_RST_CFG1 8'h80
`define NRS_RST_CFG3 8'h01
// timing
`define NRS_CLK_MHZ 125
`define NRS_AUTOLOAD_US 2000
`endif

/* File: nrs_regs.v */
// apb register bank for receive status, ring pointers, filters and page 3 configuration
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "nrs_defines.vh"
// Behaviour
// - carrier sets deferring flag, frame done clears
// - monitor mode sets disabled flag, re-enable clears
// - group destination sets bit5, individual clears
// - missed frame sets bit4, bumps missed tally
// - alignment error sets bit2, bumps alignment tally
// - crc error sets bit1, bumps crc tally
// - error-free frame sets bit0
// - boundary page readable, writable, guards ring
// - transmit start page and byte count write-only on page0, start page read back on page2
// - collision count readable at page0 offset5
// - remote start written, current address read back
// - local dma address readable at offsets 1,2
// - station address compared with incoming destination
// - current page register points at next page
// - eight multicast bytes indexed by crc hash
// - two read-only identifier bytes on page0
// - page3 power-up values fixed before loading
// - mode 01 reloads, then mode 00, cmd 21h
// - mode 10 stops dma, bits drive eeprom pins
// - config 1-3 writable only in mode 11
// - boot rom page selects one of 256
module nrs_regs #(
	parameter ADDR_W = 12,
	parameter ALD_W = 18,
	parameter AUTOLOAD_CYCLES = `NRS_AUTOLOAD_US * `NRS_CLK_MHZ,
	parameter [7:0] IDENT_FIRST = 8'h5a, // arbitrary value
	parameter [7:0] IDENT_SECOND = 8'ha5 // arbitrary value
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire carrier_seen,
	input wire monitor_mode,
	input wire rx_enable,
	input wire rx_frame_done,
	input wire rx_group_addr,
	input wire rx_crc_bad,
	input wire rx_align_bad,
	input wire rx_missed,
	input wire rx_dest_valid,
	input wire [47:0] rx_dest_addr,
	input wire [5:0] rx_hash,
	input wire [7:0] rx_next_page,
	input wire [15:0] local_dma_addr,
	input wire [15:0] remote_dma_cur,
	input wire [7:0] collision_count,
	input wire [7:0] loopback_queue_peek,
	input wire [7:0] interrupt_line_state,
	input wire [7:0] config_four,
	input wire [3:0] config_zero_status,
	input wire card_number_save,
	input wire [7:0] card_number,
	input wire eeprom_data_out_pin,
	output reg [7:0] command_register_q,
	output reg [7:0] ring_start_page_q,
	output reg [7:0] ring_stop_page_q,
	output reg [7:0] ring_boundary_page_q,
	output reg [7:0] rx_current_page_q,
	output reg [7:0] tx_start_page_q,
	output reg [15:0] tx_byte_count_q,
	output reg [15:0] remote_dma_start_q,
	output reg [15:0] remote_byte_count_q,
	output reg [47:0] station_address_q,
	output reg [63:0] multicast_filter_q,
	output reg rx_disabled_q,
	output reg station_match_q,
	output reg hash_hit_q,
	output reg ring_full_q,
	output reg dma_disable_q,
	output reg autoload_busy_q,
	output reg eeprom_select_pin_q,
	output reg eeprom_clock_pin_q,
	output reg eeprom_data_in_pin_q,
	output reg [7:0] boot_rom_page_q,
	output reg [7:0] config_one_q,
	output reg [7:0] config_two_q,
	output reg [7:0] config_three_q,
	output reg [7:0] clock_halt_q
);
	localparam [ALD_W-1:0] ALD_LAST = AUTOLOAD_CYCLES[ALD_W-1:0] - 1'b1;
	reg deferring_flag_q;
	reg group_address_flag_q;
	reg missed_frame_flag_q;
	reg alignment_error_flag_q;
	reg crc_error_flag_q;
	reg rx_ok_flag_q;
	reg [7:0] align_error_tally_q;
	reg [7:0] checksum_error_tally_q;
	reg [7:0] missed_frame_tally_q;
	reg [1:0] eeprom_mode_bits_q;
	reg [1:0] config_zero_q;
	reg [7:0] factory_test_q;
	reg [7:0] saved_card_number_q;
	reg [ALD_W-1:0] ald_cnt_q;
	reg ee_dout_s1_q;
	reg ee_dout_s2_q;
	reg [7:0] rd_d;
	function [7:0] sat_inc;
		input [7:0] v;
		begin
			sat_inc = (v == 8'hff) ? v : v + 8'h01;
		end
	endfunction
	wire [1:0] page = command_register_q[7:6];
	wire [3:0] idx = paddr[5:2];
	wire [7:0] wd = pwdata[7:0];
	wire bad_addr = (paddr[ADDR_W-1:6] != {(ADDR_W-6){1'b0}}) | (paddr[1:0] != 2'b00);
	wire setup = psel & ~penable;
	wire done = psel & penable & pready;
	wire wr = done & pwrite & ~pslverr & pstrb[0];
	wire rd = done & ~pwrite & ~pslverr;
	wire wr0 = wr & (page == `NRS_PAGE0);
	wire wr1 = wr & (page == `NRS_PAGE1);
	wire wr3 = wr & (page == `NRS_PAGE3);
	wire rd0 = rd & (page == `NRS_PAGE0);
	wire cfg_wen = (eeprom_mode_bits_q == `NRS_EEM_CFG_WRITE);
	wire [5:0] sta_ofs = {idx[2:0] - 3'h1, 3'b000};
	wire [5:0] mc_ofs = {idx[2:0], 3'b000};
	wire crc_any = rx_crc_bad | rx_align_bad;
	wire align_clr = rd0 & (idx == `NRS_IX_ALIGN_TALLY);
	wire crc_clr = rd0 & (idx == `NRS_IX_CRC_TALLY);
	wire miss_clr = rd0 & (idx == `NRS_IX_MISS_TALLY);
	wire [7:0] rx_status = {deferring_flag_q, rx_disabled_q, group_address_flag_q, missed_frame_flag_q,
		1'b1, alignment_error_flag_q, crc_error_flag_q, rx_ok_flag_q};
	wire [7:0] ee_cmd = {eeprom_mode_bits_q, 2'b00, eeprom_select_pin_q, eeprom_clock_pin_q,
		eeprom_data_in_pin_q, ee_dout_s2_q};
	always @* begin
		rd_d = 8'h00;
		if (idx == `NRS_IX_CMD) begin
			rd_d = command_register_q;
		end else begin
			case (page)
			`NRS_PAGE0: begin
				case (idx)
				`NRS_IX_LDMA_LO: rd_d = local_dma_addr[7:0];
				`NRS_IX_LDMA_HI: rd_d = local_dma_addr[15:8];
				`NRS_IX_BOUNDARY: rd_d = ring_boundary_page_q;
				`NRS_IX_TX_CNT_LO: rd_d = collision_count;
				`NRS_IX_TX_CNT_HI: rd_d = loopback_queue_peek;
				`NRS_IX_RDMA_LO: rd_d = remote_dma_cur[7:0];
				`NRS_IX_RDMA_HI: rd_d = remote_dma_cur[15:8];
				`NRS_IX_RCNT_LO: rd_d = IDENT_FIRST;
				`NRS_IX_RCNT_HI: rd_d = IDENT_SECOND;
				`NRS_IX_RX_STATUS: rd_d = rx_status;
				`NRS_IX_ALIGN_TALLY: rd_d = align_error_tally_q;
				`NRS_IX_CRC_TALLY: rd_d = checksum_error_tally_q;
				`NRS_IX_MISS_TALLY: rd_d = missed_frame_tally_q;
				default: rd_d = 8'h00;
				endcase
			end
			`NRS_PAGE1: begin
				if (idx <= `NRS_IX_STA_LAST) begin
					rd_d = station_address_q[sta_ofs +: 8];
				end else if (idx == `NRS_IX_CUR_PAGE) begin
					rd_d = rx_current_page_q;
				end else begin
					rd_d = multicast_filter_q[mc_ofs +: 8];
				end
			end
			`NRS_PAGE2: begin
				case (idx)
				`NRS_IX_LDMA_LO: rd_d = ring_start_page_q;
				`NRS_IX_LDMA_HI: rd_d = ring_stop_page_q;
				`NRS_IX_TX_START: rd_d = tx_start_page_q;
				default: rd_d = 8'h00;
				endcase
			end
			default: begin
				case (idx)
				`NRS_IX_EE_CMD: rd_d = ee_cmd;
				`NRS_IX_BOOT_PAGE: rd_d = boot_rom_page_q;
				`NRS_IX_CFG0: rd_d = {config_zero_q, config_zero_status, 2'b00};
				`NRS_IX_CFG1: rd_d = config_one_q;
				`NRS_IX_CFG2: rd_d = config_two_q;
				`NRS_IX_CFG3: rd_d = config_three_q;
				`NRS_IX_TEST: rd_d = factory_test_q;
				`NRS_IX_CARD_NUM: rd_d = saved_card_number_q;
				`NRS_IX_INT_STATE: rd_d = interrupt_line_state;
				`NRS_IX_CFG4: rd_d = config_four;
				default: rd_d = 8'h00;
				endcase
			end
			endcase
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= bad_addr ? 32'h00000000 : {24'h000000, rd_d};
			pready <= 1'b1;
			pslverr <= bad_addr;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_start_page_q <= `NRS_RST_ZERO;
			ring_stop_page_q <= `NRS_RST_ZERO;
			ring_boundary_page_q <= `NRS_RST_ZERO;
			tx_start_page_q <= `NRS_RST_ZERO;
			tx_byte_count_q <= 16'h0000;
			remote_dma_start_q <= 16'h0000;
			remote_byte_count_q <= 16'h0000;
			station_address_q <= 48'h000000000000;
			rx_current_page_q <= `NRS_RST_ZERO;
			multicast_filter_q <= 64'h0000000000000000;
		end else begin
			if (wr0) begin
				case (idx)
				`NRS_IX_LDMA_LO: ring_start_page_q <= wd;
				`NRS_IX_LDMA_HI: ring_stop_page_q <= wd;
				`NRS_IX_BOUNDARY: ring_boundary_page_q <= wd;
				`NRS_IX_TX_START: tx_start_page_q <= wd;
				`NRS_IX_TX_CNT_LO: tx_byte_count_q[7:0] <= wd;
				`NRS_IX_TX_CNT_HI: tx_byte_count_q[15:8] <= wd;
				`NRS_IX_RDMA_LO: remote_dma_start_q[7:0] <= wd;
				`NRS_IX_RDMA_HI: remote_dma_start_q[15:8] <= wd;
				`NRS_IX_RCNT_LO: remote_byte_count_q[7:0] <= wd;
				`NRS_IX_RCNT_HI: remote_byte_count_q[15:8] <= wd;
				default: ;
				endcase
			end
			if (wr1 && idx != `NRS_IX_CMD) begin
				if (idx <= `NRS_IX_STA_LAST) begin
					station_address_q[sta_ofs +: 8] <= wd;
				end else if (idx == `NRS_IX_CUR_PAGE) begin
					rx_current_page_q <= wd;
				end else begin
					multicast_filter_q[mc_ofs +: 8] <= wd;
				end
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_match_q <= 1'b0;
			hash_hit_q <= 1'b0;
			ring_full_q <= 1'b0;
		end else begin
			if (rx_dest_valid) begin
				station_match_q <= (rx_dest_addr == station_address_q);
				hash_hit_q <= multicast_filter_q[rx_hash];
			end
			ring_full_q <= (rx_next_page == ring_boundary_page_q);
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deferring_flag_q <= 1'b0;
			rx_disabled_q <= 1'b0;
			group_address_flag_q <= 1'b0;
			missed_frame_flag_q <= 1'b0;
			alignment_error_flag_q <= 1'b0;
			crc_error_flag_q <= 1'b0;
			rx_ok_flag_q <= 1'b0;
		end else begin
			deferring_flag_q <= carrier_seen | (deferring_flag_q & ~rx_frame_done);
			if (monitor_mode) begin
				rx_disabled_q <= 1'b1;
			end else if (rx_enable) begin
				rx_disabled_q <= 1'b0;
			end
			if (rx_frame_done) begin
				group_address_flag_q <= rx_group_addr;
				alignment_error_flag_q <= rx_align_bad;
				crc_error_flag_q <= crc_any;
				rx_ok_flag_q <= ~crc_any;
			end
			if (rx_missed) begin
				missed_frame_flag_q <= 1'b1;
			end else if (rx_frame_done) begin
				missed_frame_flag_q <= 1'b0;
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			align_error_tally_q <= `NRS_RST_ZERO;
			checksum_error_tally_q <= `NRS_RST_ZERO;
			missed_frame_tally_q <= `NRS_RST_ZERO;
		end else begin
			if (rx_frame_done && rx_align_bad) begin
				align_error_tally_q <= align_clr ? 8'h01 : sat_inc(align_error_tally_q);
			end else if (align_clr) begin
				align_error_tally_q <= `NRS_RST_ZERO;
			end
			if (rx_frame_done && crc_any) begin
				checksum_error_tally_q <= crc_clr ? 8'h01 : sat_inc(checksum_error_tally_q);
			end else if (crc_clr) begin
				checksum_error_tally_q <= `NRS_RST_ZERO;
			end
			if (rx_missed) begin
				missed_frame_tally_q <= miss_clr ? 8'h01 : sat_inc(missed_frame_tally_q);
			end else if (miss_clr) begin
				missed_frame_tally_q <= `NRS_RST_ZERO;
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_register_q <= `NRS_RST_CMD;
			eeprom_mode_bits_q <= `NRS_EEM_NORMAL;
			eeprom_select_pin_q <= 1'b0;
			eeprom_clock_pin_q <= 1'b0;
			eeprom_data_in_pin_q <= 1'b0;
			autoload_busy_q <= 1'b0;
			ald_cnt_q <= {ALD_W{1'b0}};
			boot_rom_page_q <= `NRS_RST_ZERO;
			config_zero_q <= 2'b00;
			config_one_q <= `NRS_RST_CFG1;
			config_two_q <= `NRS_RST_ZERO;
			config_three_q <= `NRS_RST_CFG3;
			factory_test_q <= `NRS_RST_ZERO;
			clock_halt_q <= `NRS_RST_CLK_HALT;
		end else begin
			if (autoload_busy_q) begin
				if (ald_cnt_q == ALD_LAST) begin
					autoload_busy_q <= 1'b0;
					eeprom_mode_bits_q <= `NRS_EEM_NORMAL;
					command_register_q <= `NRS_RST_CMD;
				end else begin
					ald_cnt_q <= ald_cnt_q + {{(ALD_W-1){1'b0}}, 1'b1};
				end
			end else begin
				if (wr && idx == `NRS_IX_CMD) begin
					command_register_q <= wd;
				end
				if (wr3 && idx == `NRS_IX_EE_CMD) begin
					eeprom_mode_bits_q <= wd[7:6];
					if (wd[7:6] == `NRS_EEM_AUTOLOAD) begin
						autoload_busy_q <= 1'b1;
						ald_cnt_q <= {ALD_W{1'b0}};
					end
					if (wd[7:6] == `NRS_EEM_PROGRAM) begin
						eeprom_select_pin_q <= wd[3];
						eeprom_clock_pin_q <= wd[2];
						eeprom_data_in_pin_q <= wd[1];
					end else begin
						eeprom_select_pin_q <= 1'b0;
						eeprom_clock_pin_q <= 1'b0;
						eeprom_data_in_pin_q <= 1'b0;
					end
				end
			end
			if (wr3) begin
				case (idx)
				`NRS_IX_BOOT_PAGE: boot_rom_page_q <= wd;
				`NRS_IX_CFG0: if (cfg_wen) config_zero_q <= wd[7:6];
				`NRS_IX_CFG1: if (cfg_wen) config_one_q <= wd;
				`NRS_IX_CFG2: if (cfg_wen) config_two_q <= wd;
				`NRS_IX_CFG3: if (cfg_wen) config_three_q <= wd;
				`NRS_IX_TEST: factory_test_q <= wd;
				`NRS_IX_CLK_HALT: clock_halt_q <= wd;
				default: ;
				endcase
			end
		end
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_disable_q <= 1'b0;
			saved_card_number_q <= `NRS_RST_ZERO;
			ee_dout_s1_q <= 1'b0;
			ee_dout_s2_q <= 1'b0;
		end else begin
			dma_disable_q <= (eeprom_mode_bits_q == `NRS_EEM_PROGRAM);
			if (card_number_save) begin
				saved_card_number_q <= card_number;
			end
			ee_dout_s1_q <= eeprom_data_out_pin;
			ee_dout_s2_q <= ee_dout_s1_q;
		end
	end
endmodule

/* File: nrs_chk_assertions.sv */
// port assertions for the register bank
`timescale 1ns/1ns
module nrs_chk #(
	parameter ADDR_W = 12,
	parameter [7:0] IDENT_FIRST = 8'h5a // arbitrary value
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire pready,
	input wire carrier_seen,
	input wire monitor_mode,
	input wire rx_enable,
	input wire rx_disabled_q,
	input wire rx_dest_valid,
	input wire [47:0] rx_dest_addr,
	input wire [47:0] station_address_q,
	input wire station_match_q,
	input wire [7:0] command_register_q,
	input wire autoload_busy_q,
	input wire dma_disable_q,
	input wire eeprom_select_pin_q,
	input wire eeprom_clock_pin_q,
	input wire eeprom_data_in_pin_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_su = psel && !penable && !pwrite && command_register_q[7:6] == 2'h0;
	wire ee_wr = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h004 &&
		command_register_q[7:6] == 2'h3 && !autoload_busy_q;
	reg [2:0] pin_q;
	always @(posedge pclk) begin
		if (ee_wr)
			pin_q <= pwdata[3:1];
	end
	AST_DEFER: assert property ($past(carrier_seen) && $past(presetn) && rd_su && paddr == 12'h030 |=> prdata[7])
		else $error("deferring flag not set");
	AST_DIS_SET: assert property (monitor_mode |=> rx_disabled_q)
		else $error("disabled flag not set");
	AST_DIS_CLR: assert property (!monitor_mode && rx_enable |=> !rx_disabled_q)
		else $error("disabled flag not cleared");
	AST_WO: assert property (rd_su && paddr == 12'h010 |=> pready && prdata == 32'h0)
		else $error("write-only register readable");
	AST_IDENT: assert property (rd_su && paddr == 12'h028 |=> pready && prdata == {24'h0, IDENT_FIRST})
		else $error("identifier byte wrong");
	AST_STA: assert property (rx_dest_valid && rx_dest_addr == station_address_q |-> ##[1:2] station_match_q)
		else $error("station match missed");
	AST_PINS: assert property (ee_wr && pwdata[7:6] == 2'h2 |-> ##[1:2]
		{eeprom_select_pin_q, eeprom_clock_pin_q, eeprom_data_in_pin_q} == pin_q)
		else $error("eeprom pins wrong");
	AST_DMA: assert property (ee_wr && pwdata[7:6] == 2'h2 |-> ##[1:2] dma_disable_q)
		else $error("dma not disabled");
	AST_ALD_GO: assert property (ee_wr && pwdata[7:6] == 2'h1 |-> ##[1:2] autoload_busy_q)
		else $error("reload not started");
	AST_ALD_END: assert property ($fell(autoload_busy_q) |-> command_register_q == 8'h21)
		else $error("command not restored");
endmodule
bind nrs_regs nrs_chk #(.ADDR_W(ADDR_W), .IDENT_FIRST(IDENT_FIRST)) u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .carrier_seen, .monitor_mode, .rx_enable, .rx_disabled_q,
	.rx_dest_valid, .rx_dest_addr, .station_address_q, .station_match_q, .command_register_q, .autoload_busy_q,
	.dma_disable_q, .eeprom_select_pin_q, .eeprom_clock_pin_q, .eeprom_data_in_pin_q);

/* File: nrs_host.sv */
// apb host model issuing register reads and writes
`timescale 1ns/1ns
module nrs_host (
	input wire pclk,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	output reg psel,
	output reg penable,
	output reg pwrite,
	output reg [11:0] paddr,
	output reg [31:0] pwdata,
	output reg [3:0] pstrb
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h1;
	end
	task xfer(input w, input [11:0] a, input [7:0] d, output [31:0] q, output e);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			paddr <= ~a;
			pwdata <= ~{24'h0, d};
			@(posedge pclk);
		end
	endtask
endmodule

/* File: nrs_regs_bench.sv */
// self-checking bench for the register bank
`timescale 1ns/1ns
module nrs_regs_bench;
	localparam [7:0] ID_A = 8'h3c; // arbitrary value
	localparam [7:0] ID_B = 8'hc3; // arbitrary value
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg carrier_seen = 1'b0, monitor_mode = 1'b0, rx_enable = 1'b1, rx_frame_done = 1'b0, rx_group_addr = 1'b0;
	reg rx_crc_bad = 1'b0, rx_align_bad = 1'b0, rx_missed = 1'b0, rx_dest_valid = 1'b0, card_number_save = 1'b0;
	reg eeprom_data_out_pin = 1'b1;
	reg [47:0] rx_dest_addr = 48'h0;
	reg [5:0] rx_hash = 6'h0;
	reg [7:0] rx_next_page = 8'h0, collision_count = 8'h03, loopback_queue_peek = 8'h0;
	reg [7:0] interrupt_line_state = 8'h0, config_four = 8'h0, card_number = 8'h0;
	reg [15:0] local_dma_addr = 16'h1234, remote_dma_cur = 16'h5678;
	reg [3:0] config_zero_status = 4'h0;
	wire psel, penable, pwrite, pready, pslverr, rx_disabled_q, station_match_q, hash_hit_q, dma_disable_q;
	wire autoload_busy_q, eeprom_select_pin_q, eeprom_clock_pin_q, eeprom_data_in_pin_q, ring_full_q;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [3:0] pstrb;
	wire [7:0] command_register_q, ring_stop_page_q, tx_start_page_q, config_one_q, clock_halt_q;
	wire [7:0] ring_start_page_q, ring_boundary_page_q, rx_current_page_q;
	wire [7:0] boot_rom_page_q, config_two_q, config_three_q;
	wire [15:0] tx_byte_count_q, remote_dma_start_q, remote_byte_count_q;
	wire [47:0] station_address_q;
	wire [63:0] multicast_filter_q;
	integer err_count = 0, cmp_count = 0, cyc = 0, i, n;
	reg [31:0] v;
	reg er;
	always #4 pclk = ~pclk;
	nrs_regs #(.AUTOLOAD_CYCLES(20), .IDENT_FIRST(ID_A), .IDENT_SECOND(ID_B)) uut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .carrier_seen, .monitor_mode,
		.rx_enable, .rx_frame_done, .rx_group_addr, .rx_crc_bad, .rx_align_bad, .rx_missed, .rx_dest_valid,
		.rx_dest_addr, .rx_hash, .rx_next_page, .local_dma_addr, .remote_dma_cur, .collision_count,
		.loopback_queue_peek, .interrupt_line_state, .config_four, .config_zero_status, .card_number_save,
		.card_number, .eeprom_data_out_pin, .command_register_q, .ring_start_page_q, .ring_stop_page_q,
		.ring_boundary_page_q, .rx_current_page_q, .tx_start_page_q, .tx_byte_count_q, .remote_dma_start_q,
		.remote_byte_count_q, .station_address_q, .multicast_filter_q, .rx_disabled_q, .station_match_q,
		.hash_hit_q, .ring_full_q, .dma_disable_q, .autoload_busy_q, .eeprom_select_pin_q, .eeprom_clock_pin_q,
		.eeprom_data_in_pin_q, .boot_rom_page_q, .config_one_q, .config_two_q, .config_three_q, .clock_halt_q);
	nrs_host u_host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
	task close_out;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, err_count);
			if (err_count == 0 && cmp_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task w(input [3:0] a, input [7:0] d);
		u_host.xfer(1'b1, {6'h0, a, 2'h0}, d, v, er);
	endtask
	task r(input [3:0] a, input [7:0] e);
		begin
			u_host.xfer(1'b0, {6'h0, a, 2'h0}, 8'h0, v, er);
			chk({32'h0, v}, {56'h0, e});
		end
	endtask
	task frm(input g, input c, input a);
		begin
			rx_group_addr <= g;
			rx_crc_bad <= c;
			rx_align_bad <= a;
			rx_frame_done <= 1'b1;
			@(posedge pclk);
			rx_frame_done <= 1'b0;
		end
	endtask
	task dv(input [47:0] a, input [5:0] h);
		begin
			rx_dest_addr <= a;
			rx_hash <= h;
			rx_dest_valid <= 1'b1;
			@(posedge pclk);
			rx_dest_valid <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		r(4'h0, 8'h21);
		w(4'h0, 8'he1);
		r(4'h2, 8'h00);
		r(4'h8, 8'h00);
		chk(64'(clock_halt_q), 64'hff);
		w(4'h4, 8'h55);
		chk(64'(config_one_q), 64'h80);
		w(4'h1, 8'hc0);
		w(4'h4, 8'h55);
		chk(64'(config_one_q), 64'h55);
		w(4'h5, 8'h66);
		w(4'h6, 8'h77);
		chk(64'({config_two_q, config_three_q}), 64'h6677);
		w(4'h2, 8'hff);
		r(4'h2, 8'hff);
		chk(64'(boot_rom_page_q), 64'hff);
		w(4'h1, 8'h8a);
		repeat (2) @(posedge pclk);
		chk(64'({dma_disable_q, eeprom_select_pin_q, eeprom_clock_pin_q, eeprom_data_in_pin_q}), 64'hd);
		r(4'h1, 8'h8b);
		eeprom_data_out_pin <= 1'b0;
		repeat (2) @(posedge pclk);
		r(4'h1, 8'h8a);
		w(4'h1, 8'h40);
		n = 0;
		while (autoload_busy_q !== 1'b0 && n < 100) begin
			@(posedge pclk);
			n = n + 1;
		end
		chk(64'(n > 14 && n < 26), 64'h1);
		r(4'h0, 8'h21);
		w(4'h3, 8'h4c);
		r(4'h3, 8'h4c);
		chk(64'(ring_boundary_page_q), 64'h4c);
		rx_next_page <= 8'h4c;
		repeat (2) @(posedge pclk);
		chk(64'(ring_full_q), 64'h1);
		rx_next_page <= 8'h4d;
		repeat (2) @(posedge pclk);
		chk(64'(ring_full_q), 64'h0);
		w(4'h2, 8'h60);
		chk(64'(ring_stop_page_q), 64'h60);
		w(4'h1, 8'h46);
		w(4'h0, 8'ha1);
		r(4'h1, 8'h46);
		r(4'h2, 8'h60);
		w(4'h0, 8'h21);
		chk(64'(ring_start_page_q), 64'h46);
		w(4'h4, 8'h40);
		w(4'h5, 8'h34);
		w(4'h6, 8'h12);
		chk(64'({tx_start_page_q, tx_byte_count_q}), 64'h401234);
		r(4'h4, 8'h00);
		r(4'h5, 8'h03);
		w(4'h8, 8'hcd);
		w(4'h9, 8'hab);
		w(4'ha, 8'h22);
		w(4'hb, 8'h11);
		chk(64'({remote_dma_start_q, remote_byte_count_q}), 64'habcd1122);
		r(4'h8, 8'h78);
		r(4'h9, 8'h56);
		r(4'h1, 8'h34);
		r(4'h2, 8'h12);
		r(4'ha, ID_A);
		r(4'hb, ID_B);
		u_host.xfer(1'b0, 12'h040, 8'h0, v, er);
		chk(64'({er, v}), 64'h100000000);
		frm(1'b1, 1'b0, 1'b0);
		r(4'hc, 8'h29);
		frm(1'b0, 1'b1, 1'b0);
		r(4'hc, 8'h0a);
		frm(1'b0, 1'b0, 1'b1);
		r(4'hc, 8'h0e);
		rx_missed <= 1'b1;
		@(posedge pclk);
		rx_missed <= 1'b0;
		r(4'hc, 8'h1e);
		carrier_seen <= 1'b1;
		@(posedge pclk);
		carrier_seen <= 1'b0;
		r(4'hc, 8'h9e);
		monitor_mode <= 1'b1;
		@(posedge pclk);
		r(4'hc, 8'hde);
		chk(64'(rx_disabled_q), 64'h1);
		monitor_mode <= 1'b0;
		@(posedge pclk);
		r(4'hc, 8'h9e);
		r(4'hd, 8'h01);
		r(4'he, 8'h02);
		r(4'hf, 8'h01);
		r(4'hd, 8'h00);
		w(4'h0, 8'h61);
		for (i = 1; i < 7; i = i + 1)
			w(i[3:0], 8'h10 + i[7:0]);
		chk(64'(station_address_q), 64'h161514131211);
		dv(48'h161514131211, 6'd0);
		chk(64'(station_match_q), 64'h1);
		dv(48'h161514131210, 6'd0);
		chk(64'(station_match_q), 64'h0);
		w(4'h7, 8'h46);
		r(4'h7, 8'h46);
		chk(64'(rx_current_page_q), 64'h46);
		for (i = 8; i < 16; i = i + 1)
			w(i[3:0], 8'(1 << (i - 8)));
		chk(multicast_filter_q, 64'h8040201008040201);
		r(4'hb, 8'h08);
		dv(48'h0, 6'd63);
		chk(64'(hash_hit_q), 64'h1);
		dv(48'h0, 6'd62);
		chk(64'(hash_hit_q), 64'h0);
		close_out;
	end
endmodule
